/* rps_pkg.sv */
// Shared constants, types and register map of the power sequencer
package rps_pkg;
  // Timing base
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned OSC_HZ = 101_000;
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
  localparam logic [7:0] OSC_DIV_LAST = 8'(OSC_DIV - 1);
  localparam int unsigned CNT_WIDTH = 8;
  localparam int unsigned PWM_DIV = 256;
  localparam int unsigned START_DELAY_MS = 500;
  // Least time: rounded up to whole base periods
  localparam int unsigned START_DELAY_TICKS =
    (START_DELAY_MS * OSC_HZ + PWM_DIV * 1000 - 1) / (PWM_DIV * 1000);
  localparam int unsigned POLL_PERIOD_TICKS = 16;
  localparam int unsigned OFF_HOLD_TICKS = 2 * POLL_PERIOD_TICKS;
  // Phase window in base periods and edge limits
  localparam int unsigned PH_WINDOW_TICKS = 8;
  localparam int unsigned PH_LOW_EDGES_MIN = 1;
  localparam int unsigned PH_HIGH_EDGES_MAX = 6;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h0C;
  // Control field and register reset values
  localparam int unsigned CTRL_LAMP_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
  // Event bit positions
  localparam int unsigned EV_IGN_ON = 0;
  localparam int unsigned EV_RUN = 1;
  localparam int unsigned EV_STANDBY = 2;
  localparam int unsigned EV_REMOTE_LOSS = 3;
  localparam int unsigned EV_SETPOINT = 4;
  localparam int unsigned EV_COUNT = 5;

  typedef enum logic [1:0] {
    RPS_STANDBY = 2'b00,
    RPS_START_DELAY = 2'b01,
    RPS_RUN = 2'b10,
    RPS_SHUTDOWN = 2'b11
  } rps_state_type;

  // Comparator pins after synchronising
  typedef struct packed {
    logic ign_on;
    logic remote_ok;
    logic phase;
    logic rate_test;
    logic setpoint;
  } rps_pins_type;

  // Supply and mode outputs
  typedef struct packed {
    logic normal_mode;
    logic supply_boost_en;
    logic bias_en;
    logic logic_reset;
  } rps_power_type;
endpackage : rps_pkg

/* rps_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module rps_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : rps_sync

/* rps_freq.sv */
// Phase frequency window detector against the PWM base rate
`timescale 1ns/1ps
module rps_freq #(
  parameter int unsigned WINDOW = rps_pkg::PH_WINDOW_TICKS,
  parameter int unsigned LOW_MIN = rps_pkg::PH_LOW_EDGES_MIN,
  parameter int unsigned HIGH_MAX = rps_pkg::PH_HIGH_EDGES_MAX
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic hold,
  input wire logic base_tick,
  input wire logic phase,
  // Indicators
  output logic low_speed,
  output logic high_speed
);
  logic [3:0] win_q, win_d;
  logic [3:0] edges_q, edges_d;
  logic phase_q;
  logic low_q, low_d, high_q, high_d;
  logic rise;

  assign rise = phase & ~phase_q;

  always_comb
  begin
    win_d = win_q;
    edges_d = edges_q;
    low_d = low_q;
    high_d = high_q;
    if (rise && edges_q != 4'hF)
      edges_d = edges_q + 4'h1;
    if (hold)
    begin
      win_d = '0;
      edges_d = '0;
      low_d = 1'b1;
      high_d = 1'b0;
    end
    else if (base_tick)
    begin
      win_d = win_q + 4'h1;
      if (win_q == 4'(WINDOW - 1))
      begin
        // Below base/8 and above 3/4 of base over an 8-period window
        low_d = edges_d < 4'(LOW_MIN);
        high_d = edges_d > 4'(HIGH_MAX);
        win_d = '0;
        edges_d = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      win_q <= '0;
      edges_q <= '0;
      phase_q <= 1'b0;
      low_q <= 1'b1;
      high_q <= 1'b0;
    end
    else
    begin
      win_q <= win_d;
      edges_q <= edges_d;
      phase_q <= phase;
      low_q <= low_d;
      high_q <= high_d;
    end
  end

  assign low_speed = low_q;
  assign high_speed = high_q;

  idle_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    hold |=> low_speed && !high_speed)
    else $error("Indicators not cleared while held");
endmodule : rps_freq

/* rps_top.sv */
// Ignition sequencer, timebase and sense selection with APB registers
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module rps_top #(
  parameter int unsigned START_TICKS = rps_pkg::START_DELAY_TICKS,
  parameter int unsigned HOLD_TICKS = rps_pkg::OFF_HOLD_TICKS,
  parameter int unsigned POLL_TICKS = rps_pkg::POLL_PERIOD_TICKS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Comparator pins
  input wire logic ign_comp_in,
  input wire logic remote_ok_in,
  input wire logic phase_in,
  input wire logic rate_test_input,
  input wire logic setpoint_in,
  // Supply and mode
  output rps_pkg::rps_power_type power,
  output logic load_response_ramp,
  output logic lamp_drive,
  // Sense path
  output logic remote_select,
  output logic local_select_switch_a,
  output logic local_select_switch_b,
  // Timebase and speed
  output logic low_speed_indicator,
  output logic high_speed_indicator,
  output logic pwm_base,
  output logic [7:0] count_bits,
  output logic [3:0] ramp_bits
);
  rps_pkg::rps_pins_type pins_raw, pins;
  rps_pkg::rps_state_type state_q, state_d;
  logic [7:0] div_q, div_d;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] dly_q, dly_d;
  logic [7:0] offc_q, offc_d;
  logic [3:0] poll_q, poll_d;
  logic started_q, started_d, force_q, force_d;
  logic lrr_q, lrr_d, lamp_q, lamp_d, rem_q, rem_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] prdata_q, prdata_d;
  logic [4:0] ist_q, ist_d, imask_q, imask_d;
  logic [4:0] ev;
  logic standby, osc_tick, base_tick, poll_win, off_ok, lamp_cmd;
  logic low_spd, high_spd;
  logic wr, rd, hit;

  function automatic logic is_reg(input logic [7:0] a);
    is_reg = a == rps_pkg::CTRL_OFF || a == rps_pkg::STATUS_OFF ||
      a == rps_pkg::IRQ_STAT_OFF || a == rps_pkg::IRQ_MASK_OFF;
  endfunction : is_reg

  assign pins_raw = '{ign_on: ign_comp_in, remote_ok: remote_ok_in, phase: phase_in,
    rate_test: rate_test_input, setpoint: setpoint_in};

  rps_sync #(
    .WIDTH($bits(rps_pkg::rps_pins_type))
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  assign standby = state_q == rps_pkg::RPS_STANDBY;

  rps_freq u_freq (
    .pclk(pclk),
    .presetn(presetn),
    .hold(standby),
    .base_tick(base_tick),
    .phase(pins.phase),
    .low_speed(low_spd),
    .high_speed(high_spd)
  );

  // Oscillator stand-in: fixed divide of pclk
  assign osc_tick = div_q == rps_pkg::OSC_DIV_LAST;
  // Base period ends at MSB wrap, or at bit-three wrap in rate test
  assign base_tick = osc_tick && (pins.rate_test ? cnt_q[3:0] == 4'hF : cnt_q == 8'hFF);
  assign poll_win = poll_q == 4'h0;
  assign lamp_cmd = ctrl_q[rps_pkg::CTRL_LAMP_BIT];
  // Lamp off: accept at once; lamp on: only after the hold span
  assign off_ok = !pins.ign_on && (!lamp_cmd || offc_q >= 8'(HOLD_TICKS));

  always_comb
  begin
    div_d = osc_tick ? 8'h00 : div_q + 8'h01;
    cnt_d = cnt_q;
    dly_d = dly_q;
    offc_d = offc_q;
    poll_d = poll_q;
    state_d = state_q;
    started_d = started_q;
    force_d = force_q;
    if (osc_tick)
      cnt_d = cnt_q + 8'h01;
    if (base_tick)
      poll_d = (poll_q == 4'(POLL_TICKS - 1)) ? 4'h0 : poll_q + 4'h1;
    if (pins.ign_on)
      offc_d = '0;
    else if (base_tick && offc_q != 8'hFF)
      offc_d = offc_q + 8'h01;
    case (state_q)
      rps_pkg::RPS_STANDBY:
      begin
        if (pins.ign_on)
          state_d = rps_pkg::RPS_START_DELAY;
      end
      rps_pkg::RPS_START_DELAY:
      begin
        if (off_ok)
          state_d = rps_pkg::RPS_STANDBY;
        else if (base_tick)
        begin
          dly_d = dly_q + 8'h01;
          if (dly_q == 8'(START_TICKS - 1))
            state_d = rps_pkg::RPS_RUN;
        end
      end
      rps_pkg::RPS_RUN:
      begin
        if (off_ok)
          state_d = rps_pkg::RPS_SHUTDOWN;
      end
      rps_pkg::RPS_SHUTDOWN:
      begin
        if (pins.ign_on)
          state_d = rps_pkg::RPS_RUN;
        else if (low_spd)
          state_d = rps_pkg::RPS_STANDBY;
      end
      default:
        state_d = rps_pkg::RPS_STANDBY;
    endcase
    // Rotation seen after supplies come up counts as engine start
    if (state_q == rps_pkg::RPS_RUN && !low_spd && !started_q)
    begin
      started_d = 1'b1;
      force_d = 1'b1;
    end
    else if (force_q && pins.setpoint)
      force_d = 1'b0;
    // Cleared on entry too, so standby never shows a stale count
    if (standby || state_d == rps_pkg::RPS_STANDBY)
    begin
      cnt_d = '0;
      dly_d = '0;
      offc_d = '0;
      poll_d = '0;
      started_d = 1'b0;
      force_d = 1'b0;
    end
  end

  always_comb
  begin
    lrr_d = !standby && (force_q || (!low_spd && !high_spd));
    lamp_d = !standby && lamp_cmd && !poll_win;
    rem_d = pins.remote_ok;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= rps_pkg::RPS_STANDBY;
      div_q <= '0;
      cnt_q <= '0;
      dly_q <= '0;
      offc_q <= '0;
      poll_q <= '0;
      started_q <= 1'b0;
      force_q <= 1'b0;
      lrr_q <= 1'b0;
      lamp_q <= 1'b0;
      rem_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      dly_q <= dly_d;
      offc_q <= offc_d;
      poll_q <= poll_d;
      started_q <= started_d;
      force_q <= force_d;
      lrr_q <= lrr_d;
      lamp_q <= lamp_d;
      rem_q <= rem_d;
    end
  end

  // Events for the sticky status
  always_comb
  begin
    ev = '0;
    ev[rps_pkg::EV_IGN_ON] = standby && state_d == rps_pkg::RPS_START_DELAY;
    ev[rps_pkg::EV_RUN] = state_q == rps_pkg::RPS_START_DELAY && state_d == rps_pkg::RPS_RUN;
    ev[rps_pkg::EV_STANDBY] = !standby && state_d == rps_pkg::RPS_STANDBY;
    ev[rps_pkg::EV_REMOTE_LOSS] = rem_q && !pins.remote_ok;
    ev[rps_pkg::EV_SETPOINT] = force_q && pins.setpoint && !standby;
  end

  // Zero-wait APB slave
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign hit = is_reg(paddr);

  always_comb
  begin
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    ist_d = ist_q;
    prdata_d = prdata_q;
    // Loaded in the setup cycle, so it stands through the access phase
    if (rd && !penable)
    begin
      case (paddr)
        rps_pkg::CTRL_OFF: prdata_d = ctrl_q;
        rps_pkg::STATUS_OFF: prdata_d = {22'h00_0000, state_q, force_q, lamp_q,
          high_spd, low_spd, rem_q, pins.ign_on, pins.rate_test, pins.setpoint};
        rps_pkg::IRQ_STAT_OFF: prdata_d = {27'h000_0000, ist_q};
        rps_pkg::IRQ_MASK_OFF: prdata_d = {27'h000_0000, imask_q};
        default: prdata_d = '0;
      endcase
    end
    if (wr && paddr == rps_pkg::CTRL_OFF)
      ctrl_d = {31'h0000_0000, pwdata[rps_pkg::CTRL_LAMP_BIT]};
    if (wr && paddr == rps_pkg::IRQ_MASK_OFF)
      imask_d = pwdata[4:0];
    if (wr && paddr == rps_pkg::IRQ_STAT_OFF)
      ist_d = ist_q & ~pwdata[4:0];
    // Set beats a same-cycle clear
    ist_d = ist_d | ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= rps_pkg::CTRL_RESET;
      imask_q <= rps_pkg::IRQ_MASK_RESET;
      ist_q <= '0;
      prdata_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      imask_q <= imask_d;
      ist_q <= ist_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign irq = |(ist_q & imask_q);

  // Outputs
  assign power = '{normal_mode: !standby, supply_boost_en: state_q[1],
    bias_en: state_q[1], logic_reset: standby};
  assign load_response_ramp = lrr_q;
  assign lamp_drive = lamp_q;
  assign remote_select = rem_q;
  assign local_select_switch_a = !rem_q;
  assign local_select_switch_b = !rem_q;
  assign low_speed_indicator = low_spd;
  assign high_speed_indicator = high_spd;
  assign pwm_base = pins.rate_test ? cnt_q[3] : cnt_q[7];
  assign count_bits = cnt_q;
  assign ramp_bits = cnt_q[7:4];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence ign_seen_s;
    standby && pins.ign_on;
  endsequence

  ign_start_a: assert property (ign_seen_s |=> state_q == rps_pkg::RPS_START_DELAY)
    else $error("Ignition on did not leave standby");
  standby_hold_a: assert property (standby |-> cnt_q == 8'h00 && !force_q)
    else $error("Logic running in standby");
  start_delay_a: assert property ($rose(state_q == rps_pkg::RPS_RUN) && !started_q &&
    $past(state_q) == rps_pkg::RPS_START_DELAY |-> $past(dly_q) == 8'(START_TICKS - 1))
    else $error("Supplies enabled before start delay");
  ramp_end_a: assert property (force_q && pins.setpoint && !standby |=> !force_q ##1
    (!lrr_q || $past(!low_spd && !high_spd)))
    else $error("Ramp mode not released at setpoint");
  shutdown_a: assert property (state_q == rps_pkg::RPS_SHUTDOWN && !pins.ign_on && low_spd
    |=> standby)
    else $error("Standby not reached at low rotation");
  lamp_poll_a: assert property (lamp_cmd && poll_win |=> !lamp_drive)
    else $error("Lamp not polled off");
  off_hold_a: assert property (state_q == rps_pkg::RPS_RUN && lamp_cmd && !pins.ign_on &&
    offc_q < 8'(HOLD_TICKS) |=> state_q == rps_pkg::RPS_RUN)
    else $error("Ignition off accepted inside hold time");
  sense_sel_a: assert property (pins.remote_ok |=> remote_select && !local_select_switch_a
    && !local_select_switch_b)
    else $error("Remote path not selected");
  count_step_a: assert property (osc_tick && !standby && state_d != rps_pkg::RPS_STANDBY
    |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("Counter missed an oscillator tick");
  base_norm_a: assert property (base_tick && !pins.rate_test |-> cnt_q == 8'hFF)
    else $error("Normal base period not divide by 256");
  base_test_a: assert property (base_tick && pins.rate_test |-> cnt_q[3:0] == 4'hF)
    else $error("Test base period not divide by 16");
endmodule : rps_top

/* rps_far_side.sv */
// Far-side model: ignition switch, fault lamp wiring and phase tap
`timescale 1ns/1ps
module rps_far_side (
  // Clock
  input wire logic pclk,
  // Scenario controls
  input wire logic ign_switch,
  input wire logic via_lamp,
  input wire logic [15:0] phase_half,
  // Device pins
  input wire logic lamp_drive,
  output logic ign_comp_in,
  output logic phase_in
);
  logic [15:0] cnt_q = 16'h0000;
  logic level_q = 1'b0;
  // Lamp in series: a conducting lamp pulls the sense node low
  assign ign_comp_in = ign_switch & ~(via_lamp & lamp_drive);
  assign phase_in = level_q;
  // Stopped rotor holds its last level, as a real stator tap does
  always @(posedge pclk)
  begin
    if (phase_half == 16'h0000)
    begin
      cnt_q <= 16'h0000;
    end
    else if (cnt_q >= phase_half - 16'h0001)
    begin
      cnt_q <= 16'h0000;
      level_q <= ~level_q;
    end
    else
    begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule : rps_far_side

/* rps_tb_top.sv */
// Self-checking bench for the power sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module rps_tb_top;
  // Rate test on apart from one 2000-cycle stretch: one base period is 16 oscillator ticks
  localparam int unsigned BASE = 16 * rps_pkg::OSC_DIV;
  localparam int unsigned ST = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic ign_comp_in;
  logic remote_ok_in = 1'b1;
  logic phase_in;
  logic rate_test_input = 1'b1;
  logic setpoint_in = 1'b0;
  rps_pkg::rps_power_type power;
  logic load_response_ramp;
  logic lamp_drive;
  logic remote_select;
  logic local_select_switch_a;
  logic local_select_switch_b;
  logic low_speed_indicator;
  logic high_speed_indicator;
  logic pwm_base;
  logic [7:0] count_bits;
  logic [3:0] ramp_bits;
  logic ign_switch = 1'b0;
  logic via_lamp = 1'b0;
  logic [15:0] phase_half = 16'h0000;
  logic chk_on = 1'b1;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;

  rps_top #(.START_TICKS(ST), .HOLD_TICKS(4), .POLL_TICKS(2)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .ign_comp_in(ign_comp_in), .remote_ok_in(remote_ok_in), .phase_in(phase_in),
    .rate_test_input(rate_test_input), .setpoint_in(setpoint_in), .power(power),
    .load_response_ramp(load_response_ramp), .lamp_drive(lamp_drive),
    .remote_select(remote_select), .local_select_switch_a(local_select_switch_a),
    .local_select_switch_b(local_select_switch_b), .low_speed_indicator(low_speed_indicator),
    .high_speed_indicator(high_speed_indicator), .pwm_base(pwm_base),
    .count_bits(count_bits), .ramp_bits(ramp_bits));

  rps_far_side far (
    .pclk(pclk), .ign_switch(ign_switch), .via_lamp(via_lamp), .phase_half(phase_half),
    .lamp_drive(lamp_drive), .ign_comp_in(ign_comp_in), .phase_in(phase_in));

  always #25 pclk = ~pclk;

  task automatic wrap_up();
    if (mismatches == 0 && cmp_count > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  // Sampled mid-cycle; paused while the test pin crosses its synchroniser
  always @(negedge pclk)
  begin
    if (presetn && chk_on)
    begin
      `CHK(ramp_bits, count_bits[7:4])
      `CHK(pwm_base, rate_test_input ? count_bits[3] : count_bits[7])
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // One APB transfer; an idle cycle after it keeps requests apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                     output logic [31:0] d, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  initial
  begin
    logic [31:0] d;
    logic e;
    logic [7:0] c;
    int i;
    int low_n;
    int on_n;
    int drop_n;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(power, 4'b0001)
    `CHK(low_speed_indicator, 1'b1)
    apb(1'b0, rps_pkg::CTRL_OFF, 32'h0000_0000, d, e);
    `CHK(d, rps_pkg::CTRL_RESET)
    apb(1'b0, rps_pkg::IRQ_MASK_OFF, 32'h0000_0000, d, e);
    `CHK(d[4:0], rps_pkg::IRQ_MASK_RESET)
    apb(1'b0, 8'h10, 32'h0000_0000, d, e);
    `CHK({d, e}, 33'h0_0000_0001)
    apb(1'b1, rps_pkg::IRQ_MASK_OFF, 32'h0000_001F, d, e);
    apb(1'b1, rps_pkg::IRQ_STAT_OFF, 32'h0000_001F, d, e);
    tick(500);
    `CHK(count_bits, 8'h00)
    `CHK(irq, 1'b0)
    // Ignition on with the engine already turning fast
    ign_switch <= 1'b1;
    phase_half <= 16'(BASE / 4);
    tick(5);
    `CHK(power, 4'b1000)
    `CHK(irq, 1'b1)
    tick((ST - 1) * BASE - 20);
    `CHK(power.supply_boost_en, 1'b0)
    for (i = 0; i < 3 * BASE && power.supply_boost_en !== 1'b1; i++) @(posedge pclk);
    `CHK(power, 4'b1110)
    apb(1'b1, rps_pkg::IRQ_MASK_OFF, 32'h0000_0000, d, e);
    `CHK(irq, 1'b0)
    apb(1'b1, rps_pkg::IRQ_MASK_OFF, 32'h0000_001F, d, e);
    `CHK(irq, 1'b1)
    apb(1'b0, rps_pkg::IRQ_STAT_OFF, 32'h0000_0000, d, e);
    `CHK(d[1:0], 2'b11)
    apb(1'b1, rps_pkg::IRQ_STAT_OFF, 32'h0000_0003, d, e);
    apb(1'b0, rps_pkg::IRQ_STAT_OFF, 32'h0000_0000, d, e);
    `CHK(d[1:0], 2'b00)
    // Counter steps exactly once per oscillator tick
    c = count_bits;
    for (i = 0; i < 400 && count_bits === c; i++) @(posedge pclk);
    c = count_bits;
    tick(rps_pkg::OSC_DIV - 1);
    `CHK(count_bits, c)
    tick(1);
    `CHK(count_bits, c + 8'h01)
    chk_on <= 1'b0;
    rate_test_input <= 1'b0;
    tick(4);
    chk_on <= 1'b1;
    tick(2000);
    chk_on <= 1'b0;
    rate_test_input <= 1'b1;
    tick(4);
    chk_on <= 1'b1;
    remote_ok_in <= 1'b0;
    tick(5);
    `CHK({remote_select, local_select_switch_a, local_select_switch_b}, 3'b011)
    apb(1'b0, rps_pkg::IRQ_STAT_OFF, 32'h0000_0000, d, e);
    `CHK(d[3], 1'b1)
    remote_ok_in <= 1'b1;
    tick(5);
    `CHK({remote_select, local_select_switch_a, local_select_switch_b}, 3'b100)
    // Lamp on with ignition sensed through it, until high speed shows
    apb(1'b1, rps_pkg::CTRL_OFF, 32'h0000_0001, d, e);
    via_lamp <= 1'b1;
    low_n = 0;
    on_n = 0;
    drop_n = 0;
    for (i = 0; (i < 6 * BASE || high_speed_indicator !== 1'b1) && i < 26 * BASE; i++)
    begin
      @(posedge pclk);
      if (lamp_drive === 1'b0) low_n++;
      if (lamp_drive === 1'b1) on_n++;
      if (power.supply_boost_en !== 1'b1) drop_n++;
    end
    `CHK(drop_n, 0)
    `CHK(low_n >= BASE && on_n > 0, 1'b1)
    `CHK({high_speed_indicator, low_speed_indicator}, 2'b10)
    `CHK(load_response_ramp, 1'b1)
    setpoint_in <= 1'b1;
    tick(5);
    `CHK(load_response_ramp, 1'b0)
    apb(1'b0, rps_pkg::IRQ_STAT_OFF, 32'h0000_0000, d, e);
    `CHK(d[4], 1'b1)
    // Ignition off while still turning: supplies stay until rotation stops
    apb(1'b1, rps_pkg::CTRL_OFF, 32'h0000_0000, d, e);
    via_lamp <= 1'b0;
    ign_switch <= 1'b0;
    tick(BASE);
    `CHK(power, 4'b1110)
    apb(1'b0, rps_pkg::STATUS_OFF, 32'h0000_0000, d, e);
    `CHK(d[9:8], 2'd3)
    phase_half <= 16'h0000;
    for (i = 0; i < 20 * BASE && power.logic_reset !== 1'b1; i++) @(posedge pclk);
    `CHK(power, 4'b0001)
    tick(2 * rps_pkg::OSC_DIV);
    `CHK(count_bits, 8'h00)
    apb(1'b0, rps_pkg::IRQ_STAT_OFF, 32'h0000_0000, d, e);
    `CHK(d[2], 1'b1)
    wrap_up();
  end
endmodule : rps_tb_top
